/* File: tb/fsr_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Two drives on the cable: both fitted, disk write protected, heads on track zero
module fsr_drive_model (
  input  wire logic                   clock_in,
  input  wire logic                   drive_sel0_n_in,
  input  wire logic                   drive_sel1_n_in,
  input  wire logic                   rdata_pulse_in,
  output var  fsr_pkg::fsr_drive_in_type drive_pins_out
);
  import fsr_pkg::*;

  logic [1:0] rd_cnt_q = 2'h0; // Read pulse length left

  // Read pulse lasts three clocks so it survives the two-flop synchroniser
  always_ff @(posedge clock_in) begin
    if (rdata_pulse_in) begin
      rd_cnt_q <= 2'h3;
    end else if (rd_cnt_q != 2'h0) begin
      rd_cnt_q <= rd_cnt_q - 2'h1;
    end
  end

  // Track zero is only reported by a selected drive; index stays idle
  assign drive_pins_out = fsr_drive_in_type'{drv2_n: 1'b0,
                                             trk0_n: drive_sel0_n_in & drive_sel1_n_in,
                                             index_n: 1'b1,
                                             wp_n: 1'b0,
                                             rdata_n: rd_cnt_q == 2'h0};
endmodule

`default_nettype wire

/* File: tb/tb_floppy_status_and_output_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Bench for the status and output register bank
module tb_floppy_status_and_output_regs;
  import fsr_pkg::*;

  logic             clock_in     = 1'b0;
  logic             rst_n_in     = 1'b0;
  fsr_mode_type     mode_in      = FSR_MODE_ENHANCED;
  logic [2:0]       host_addr_in = 3'h0;
  logic             host_rd_n_in = 1'b1;
  logic             host_wr_n_in = 1'b1;
  logic [7:0]       host_data_in = 8'h00;
  fsr_core_type     core_in      = '{default: 1'b0, wdata_n: 1'b1};
  logic             dir_read_in  = 1'b0;
  logic             rdata_pulse  = 1'b0;
  logic [7:0]       host_data_out;
  logic             host_data_oe_out;
  fsr_drive_in_type drive_pins;
  logic             sel0_n, sel1_n, srst_n, dma_en, dma_pins;
  logic [3:0]       motor_n;
  logic [7:0]       dor_exp      = 8'h00; // Expected output register
  logic [3:0]       lat          = 4'h0;  // Expected {step, wdata, rdata, write_gate} latches
  logic             rtog         = 1'b0;  // Expected toggle bits
  logic             wtog         = 1'b0;
  int               num_errors   = 0;
  int               samples_checked = 0;
  logic [7:0]       tbl [6]      = '{8'h1c, 8'h2d, 8'h4e, 8'h8f, 8'hf0, 8'h13};

  // Free-running 20 MHz clock
  initial begin
    forever #25 clock_in = ~clock_in;
  end

  fsr_regs uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
    .host_addr_in(host_addr_in), .host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_out(host_data_oe_out), .drive_pins_in(drive_pins), .core_in(core_in),
    .dir_read_in(dir_read_in), .drive_sel0_n_out(sel0_n), .drive_sel1_n_out(sel1_n),
    .motor_on_n_out(motor_n), .soft_reset_n_out(srst_n), .dma_irq_enable_out(dma_en),
    .dma_pins_enable_out(dma_pins));

  fsr_drive_model partner (.clock_in(clock_in), .drive_sel0_n_in(sel0_n),
    .drive_sel1_n_in(sel1_n), .rdata_pulse_in(rdata_pulse), .drive_pins_out(drive_pins));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // One counted comparison
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Selected drive {1, 0}; a drive needs its motor bit as well
  function automatic logic [1:0] sel();
    return {dor_exp[1:0] == 2'h1 && dor_exp[5], dor_exp[1:0] == 2'h0 && dor_exp[4]};
  endfunction

  // Expected status byte at offset a for present levels and mode
  function automatic logic [7:0] st(input logic [2:0] a);
    logic [1:0] s;
    s = sel();
    if (mode_in == FSR_MODE_ALTERNATE) begin
      if (a == 3'h0) return {core_in.intr, core_in.dma_request, lat[3], |s, !core_in.head_side_select, 2'h1,
                             !core_in.dir};
      return {1'b0, ~s, lat[2:0], 2'h3};
    end
    if (a == 3'h0) return {core_in.intr, 1'b0, core_in.step, ~|s, core_in.head_side_select, 2'h2,
                           core_in.dir};
    return {2'h3, dor_exp[0], wtog, rtog, core_in.write_gate, dor_exp[5:4]};
  endfunction

  // Drive-side outputs against the expected register; returns on an edge
  task automatic outs();
    #1;
    check({motor_n, sel1_n, sel0_n, srst_n, dma_en},
          {~dor_exp[7:4], ~sel(), dor_exp[2], dor_exp[3]}, "pins");
    check({7'h0, dma_pins}, {7'h0, mode_in == FSR_MODE_ENHANCED || dor_exp[3]}, "dma pins");
    @(posedge clock_in);
  endtask

  // Host write: strobe low four clocks, then four idle
  task automatic put(input logic [7:0] d);
    host_addr_in <= 3'h2;
    host_data_in <= d;
    host_wr_n_in <= 1'b0;
    cyc(4);
    host_wr_n_in <= 1'b1;
    cyc(4);
    dor_exp = d;
    outs();
  endtask

  // Host read: sample once settled, then release and let the bus drop
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic oe);
    host_addr_in <= a;
    host_rd_n_in <= 1'b0;
    cyc(4);
    #1;
    check({7'h0, host_data_oe_out}, {7'h0, oe}, "drive enable");
    if (oe) check(host_data_out, exp, "read data");
    @(posedge clock_in);
    host_rd_n_in <= 1'b1;
    cyc(4);
  endtask

  // Pulse step, read data and write data as w = {step, rdata, wdata}
  task automatic kick(input logic [2:0] w);
    core_in.step <= w[2];
    core_in.wdata_n <= !w[0];
    rdata_pulse <= w[1];
    cyc(1);
    rdata_pulse <= 1'b0;
    cyc(1);
    core_in.step <= 1'b0;
    core_in.wdata_n <= 1'b1;
    rtog ^= w[1];
    wtog ^= w[0];
    lat |= {w[2], w[0], w[1], 1'b0};
    cyc(8);
  endtask

  task automatic dir_read();
    dir_read_in <= 1'b1;
    cyc(1);
    dir_read_in <= 1'b0;
    cyc(3);
    lat = 4'h0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: the sequence needs about 500 clocks
  initial begin
    cyc(6000);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    cyc(3);
    rst_n_in <= 1'b1;
    cyc(3);
    outs();
    rd(3'h2, 8'h00, 1'b1);
    rd(3'h1, 8'hc0, 1'b1);
    rd(3'h0, st(3'h0), 1'b1);
    $display("reset test done");
    mode_in <= FSR_MODE_BASIC;
    cyc(1);
    rd(3'h0, 8'h00, 1'b0);
    rd(3'h1, 8'h00, 1'b0);
    rd(3'h3, 8'h00, 1'b0);
    put(8'h08);
    put(8'h00);
    $display("basic mode test done");
    mode_in <= FSR_MODE_ENHANCED;
    foreach (tbl[i]) begin
      put(tbl[i]);
      rd(3'h2, tbl[i], 1'b1);
      rd(3'h0, st(3'h0), 1'b1);
      rd(3'h1, st(3'h1), 1'b1);
    end
    $display("output register test done");
    put(8'h3d);
    put(8'h39);
    rd(3'h1, st(3'h1), 1'b1);
    rd(3'h2, 8'h39, 1'b1);
    put(8'h3d);
    $display("soft reset test done");
    core_in.write_gate <= 1'b1;
    repeat (2) begin
      kick(3'h3);
      rd(3'h1, st(3'h1), 1'b1);
    end
    $display("toggle test done");
    mode_in <= FSR_MODE_ALTERNATE;
    core_in <= '{intr: 1'b1, dma_request: 1'b1, head_side_select: 1'b1, dir: 1'b1, wdata_n: 1'b1, default: 1'b0};
    cyc(2);
    dir_read();
    rd(3'h1, st(3'h1), 1'b1);
    rd(3'h0, st(3'h0), 1'b1);
    core_in.write_gate <= 1'b1;
    lat[0] = 1'b1;
    kick(3'h7);
    rd(3'h0, st(3'h0), 1'b1);
    rd(3'h1, st(3'h1), 1'b1);
    dir_read();
    rd(3'h1, st(3'h1), 1'b1);
    kick(3'h4);
    put(8'h39);
    put(8'h3d);
    lat[3] = 1'b0;
    rd(3'h0, st(3'h0), 1'b1);
    $display("alternate mode test done");
    // Mid-run hardware reset: mirrors, motors and toggles must clear
    rst_n_in <= 1'b0;
    mode_in  <= FSR_MODE_ENHANCED;
    cyc(3);
    rst_n_in <= 1'b1;
    dor_exp = 8'h00;
    rtog    = 1'b0;
    wtog    = 1'b0;
    cyc(3);
    outs();
    rd(3'h1, st(3'h1), 1'b1);
    rd(3'h2, 8'h00, 1'b1);
    $display("hardware reset test done");
    give_verdict();
  end
endmodule

`default_nettype wire

/* File: verilog/fsr_params.svh */
// Contract
// RULE1 - Basic mode: first status read floats bus
// RULE2 - Other modes: both status registers always readable
// RULE3 - Enhanced first status layout and reset values
// RULE4 - Alternate first status layout and reset values
// RULE5 - Alternate step latch set, cleared by reads/resets
// RULE6 - Enhanced second status layout, reads 0xc0 reset
// RULE7 - Enhanced read/write data toggle on inactive edges
// RULE8 - Motor and select mirrors survive software reset
// RULE9 - Alternate second status layout and reset values
// RULE10 - Write gate latch: set rising, cleared by read
// RULE11 - Data latches set on inactive edge, cleared by read
// RULE12 - Output register read/write, zero reset, survives soft reset
// RULE13 - Select bits decode binary, one drive at most
// RULE14 - Bit 2 low holds reset, minimum 100ns
// RULE15 - DMA enable gates DMA and interrupt pins
// RULE16 - Enhanced mode keeps DMA pins always enabled
// RULE17 - Bits 4 to 6 assert motor 0 to 2
// RULE18 - Bit 7 asserts motor 3
// RULE19 - Mode input selects basic, enhanced, alternate
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// Register offsets on the host address lines
`define FSR_OFS_FIRST_STATUS   3'h0
`define FSR_OFS_SECOND_STATUS  3'h1
`define FSR_OFS_DIGITAL_OUTPUT 3'h2

// Digital output register fields
`define FSR_DOR_SEL_LO    0
`define FSR_DOR_SEL_HI    1
`define FSR_DOR_SOFT_RST  2
`define FSR_DOR_DMA_EN    3
`define FSR_DOR_MOTOR_LO  4
`define FSR_DOR_MOTOR_HI  7
`define FSR_DOR_RESET     8'h00

// Constant ones in the enhanced second status register
`define FSR_SRB_ENH_ONES  2'h3

// Software reset timing
`define FSR_CLK_PERIOD_NS 50
`define FSR_SWRST_MIN_NS  100
`define FSR_SWRST_CYC     ((`FSR_SWRST_MIN_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)
`define FSR_SWRST_CNT_W   3

`endif

/* File: verilog/fsr_pkg.sv */
`default_nettype none
`include "fsr_params.svh"

package fsr_pkg;

  // Interface behaviour chosen by configuration logic
  typedef enum logic [1:0] {
    FSR_MODE_BASIC,
    FSR_MODE_ENHANCED,
    FSR_MODE_ALTERNATE
  } fsr_mode_type;

  // Drive-side input pins, all active low
  typedef struct packed {
    logic drv2_n;
    logic trk0_n;
    logic index_n;
    logic wp_n;
    logic rdata_n;
  } fsr_drive_in_type;

  // Controller core status, same clock as this block
  typedef struct packed {
    logic intr;
    logic dma_request;
    logic step;
    logic dir;
    logic head_side_select;
    logic write_gate;
    logic wdata_n;
  } fsr_core_type;

  // Complete state of the register bank
  typedef struct packed {
    logic [7:0]                  digital_output_control;
    logic                        step_latch;
    logic                        write_gate_latch;
    logic                        rdata_latch;
    logic                        wdata_latch;
    logic                        rdata_tog;
    logic                        wdata_tog;
    logic                        prev_step;
    logic                        prev_write_gate;
    logic                        prev_rdata_n;
    logic                        prev_wdata_n;
    logic                        prev_wr_n;
    logic [`FSR_SWRST_CNT_W-1:0] rst_cnt;
    logic [7:0]                  data_out;
    logic                        data_oe;
    logic [3:0]                  ds_n;
    logic [3:0]                  motor_n;
    logic                        dma_pins_en;
    logic                        soft_rst_n;
  } fsr_state_type;

endpackage

`default_nettype wire

/* File: verilog/fsr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsr_params.svh"

// Status and output registers of the floppy controller
module fsr_regs (
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire fsr_pkg::fsr_mode_type     mode_in,
  input  wire logic [2:0]                host_addr_in,
  input  wire logic                      host_rd_n_in,
  input  wire logic                      host_wr_n_in,
  input  wire logic [7:0]                host_data_in,
  output logic      [7:0]                host_data_out,
  output logic                           host_data_oe_out,
  input  wire fsr_pkg::fsr_drive_in_type drive_pins_in,
  input  wire fsr_pkg::fsr_core_type     core_in,
  input  wire logic                      dir_read_in,
  output logic                           drive_sel0_n_out,
  output logic                           drive_sel1_n_out,
  output logic      [3:0]                motor_on_n_out,
  output logic                           soft_reset_n_out,
  output logic                           dma_irq_enable_out,
  output logic                           dma_pins_enable_out
);
  import fsr_pkg::*;

  // Synchronised pin bundle: strobes, address, data, drive pins
  localparam int SYNC_W = 2 + 3 + 8 + 5;

  logic [SYNC_W-1:0]   sync_raw;     // Bundle before the synchroniser
  logic [SYNC_W-1:0]   sync_val;     // Bundle after the synchroniser
  logic                rd_n_s;       // Read strobe, synchronised
  logic                wr_n_s;       // Write strobe, synchronised
  logic [2:0]          addr_s;       // Address, synchronised
  logic [7:0]          wdat_s;       // Write data, synchronised
  fsr_drive_in_type    pins_s;       // Drive pins, synchronised
  fsr_state_type       st_q;         // Registered state
  fsr_state_type       st_d;         // Next state
  logic                wr_take;      // Write accepted this cycle
  logic                rd_act;       // Read strobe active
  logic                soft_rst;     // Software reset in force
  logic [7:0]          first_stat;   // First status register value
  logic [7:0]          second_stat;  // Second status register value
  logic [1:0]          sel;          // Next drive select number

  assign sync_raw = {host_rd_n_in, host_wr_n_in, host_addr_in, host_data_in, drive_pins_in};

  // All pins pass two flops; reset to ones keeps strobes idle
  fsr_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL ({SYNC_W{1'b1}})
  ) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (sync_raw),
    .sync_out (sync_val)
  );

  assign {rd_n_s, wr_n_s, addr_s, wdat_s, pins_s} = sync_val;

  // Write taken on the falling edge of the synchronised strobe
  assign wr_take  = st_q.prev_wr_n && !wr_n_s;
  assign rd_act   = !rd_n_s;
  assign soft_rst = !st_q.soft_rst_n;

  // First status register as each mode presents it
  // RULE19 mode input picks layout
  always_comb begin
    case (mode_in)
      // RULE4 alternate first layout
      FSR_MODE_ALTERNATE: begin
        first_stat = {core_in.intr, core_in.dma_request, st_q.step_latch, !pins_s.trk0_n,
                      !core_in.head_side_select, !pins_s.index_n, !pins_s.wp_n, !core_in.dir};
      end
      // RULE3 enhanced first layout
      default: begin
        first_stat = {core_in.intr, pins_s.drv2_n, core_in.step, pins_s.trk0_n,
                      core_in.head_side_select, pins_s.index_n, pins_s.wp_n, core_in.dir};
      end
    endcase
  end

  // Second status register as each mode presents it
  always_comb begin
    case (mode_in)
      // RULE9 alternate second layout
      FSR_MODE_ALTERNATE: begin
        second_stat = {pins_s.drv2_n, st_q.ds_n[1], st_q.ds_n[0], st_q.wdata_latch,
                       st_q.rdata_latch, st_q.write_gate_latch, st_q.ds_n[3], st_q.ds_n[2]};
      end
      // RULE6 enhanced second layout
      default: begin
        second_stat = {`FSR_SRB_ENH_ONES, st_q.digital_output_control[`FSR_DOR_SEL_LO], st_q.wdata_tog,
                       st_q.rdata_tog, core_in.write_gate, !st_q.motor_n[1], !st_q.motor_n[0]};
      end
    endcase
  end

  // Next-state logic for the whole bank
  always_comb begin
    st_d = st_q;
    st_d.prev_wr_n    = wr_n_s;
    st_d.prev_step    = core_in.step;
    st_d.prev_write_gate   = core_in.write_gate;
    st_d.prev_rdata_n = pins_s.rdata_n;
    st_d.prev_wdata_n = core_in.wdata_n;

    // RULE12 output register write
    if (wr_take && addr_s == `FSR_OFS_DIGITAL_OUTPUT) begin
      st_d.digital_output_control = wdat_s;
    end

    // RULE14 reset held, minimum length counted
    if (!st_d.digital_output_control[`FSR_DOR_SOFT_RST]) begin
      st_d.rst_cnt = `FSR_SWRST_CNT_W'(`FSR_SWRST_CYC);
    end else if (st_q.rst_cnt != '0) begin
      st_d.rst_cnt = st_q.rst_cnt - 1'b1;
    end
    st_d.soft_rst_n = st_d.digital_output_control[`FSR_DOR_SOFT_RST] && (st_q.rst_cnt <= 1);

    // RULE13 binary decode gated by motor bit
    sel = st_d.digital_output_control[`FSR_DOR_SEL_HI:`FSR_DOR_SEL_LO];
    for (int i = 0; i < 4; i++) begin
      st_d.ds_n[i] = !((sel == 2'(i)) && st_d.digital_output_control[`FSR_DOR_MOTOR_LO + i]);
    end

    // RULE17 motor 0 to 2 from bits 4 to 6
    // RULE18 motor 3 from bit 7
    st_d.motor_n = ~st_d.digital_output_control[`FSR_DOR_MOTOR_HI:`FSR_DOR_MOTOR_LO];

    // RULE15 DMA pins follow enable bit
    // RULE16 enhanced mode keeps them enabled
    st_d.dma_pins_en = (mode_in == FSR_MODE_ENHANCED) || st_d.digital_output_control[`FSR_DOR_DMA_EN];

    // RULE5 step latch: clears first, set wins
    if (dir_read_in || soft_rst) begin
      st_d.step_latch = 1'b0;
    end
    if (core_in.step && !st_q.prev_step) begin
      st_d.step_latch = 1'b1;
    end

    // RULE10 write gate latch; RULE11 data latches
    if (dir_read_in) begin
      st_d.write_gate_latch = 1'b0;
      st_d.rdata_latch = 1'b0;
      st_d.wdata_latch = 1'b0;
    end
    if (core_in.write_gate && !st_q.prev_write_gate) begin
      st_d.write_gate_latch = 1'b1;
    end
    // Write data is latched whether or not write gate is on
    if (pins_s.rdata_n && !st_q.prev_rdata_n) begin
      st_d.rdata_latch = 1'b1;
    end
    if (core_in.wdata_n && !st_q.prev_wdata_n) begin
      st_d.wdata_latch = 1'b1;
    end

    // RULE7 toggles on inactive edges
    if (pins_s.rdata_n && !st_q.prev_rdata_n) begin
      st_d.rdata_tog = !st_q.rdata_tog;
    end
    if (core_in.wdata_n && !st_q.prev_wdata_n) begin
      st_d.wdata_tog = !st_q.wdata_tog;
    end

    // Host read path; registered so outputs come from flops
    st_d.data_oe  = 1'b0;
    st_d.data_out = 8'h00;
    if (rd_act) begin
      case (addr_s)
        // RULE1 basic mode floats; RULE2 other modes answer
        `FSR_OFS_FIRST_STATUS: begin
          st_d.data_oe  = (mode_in != FSR_MODE_BASIC);
          st_d.data_out = first_stat;
        end
        `FSR_OFS_SECOND_STATUS: begin
          st_d.data_oe  = (mode_in != FSR_MODE_BASIC);
          st_d.data_out = second_stat;
        end
        `FSR_OFS_DIGITAL_OUTPUT: begin
          st_d.data_oe  = 1'b1;
          st_d.data_out = st_q.digital_output_control;
        end
        // Other offsets belong to other registers
        default: begin
          st_d.data_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; software reset never touches the output register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // RULE8 mirrors clear only on hardware reset
      st_q              <= '0;
      st_q.digital_output_control          <= `FSR_DOR_RESET;
      st_q.ds_n         <= 4'hf;
      st_q.motor_n      <= 4'hf;
      st_q.prev_wr_n    <= 1'b1;
      st_q.prev_rdata_n <= 1'b1;
      st_q.prev_wdata_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign host_data_out       = st_q.data_out;
  assign host_data_oe_out    = st_q.data_oe;
  assign drive_sel0_n_out    = st_q.ds_n[0];
  assign drive_sel1_n_out    = st_q.ds_n[1];
  assign motor_on_n_out      = st_q.motor_n;
  assign soft_reset_n_out    = st_q.soft_rst_n;
  assign dma_irq_enable_out  = st_q.digital_output_control[`FSR_DOR_DMA_EN];
  assign dma_pins_enable_out = st_q.dma_pins_en;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Helper views for the checks below
  logic [3:0] wdat_motor;
  logic       is_status_addr;
  assign wdat_motor     = wdat_s[`FSR_DOR_MOTOR_HI:`FSR_DOR_MOTOR_LO];
  assign is_status_addr = (addr_s == `FSR_OFS_FIRST_STATUS) ||
                          (addr_s == `FSR_OFS_SECOND_STATUS);

  sequence dor_write_s;
    wr_take && addr_s == `FSR_OFS_DIGITAL_OUTPUT;
  endsequence

  sequence soft_rst_write_s;
    dor_write_s ##0 !wdat_s[`FSR_DOR_SOFT_RST];
  endsequence

  basic_read_float_a: assert property ( // RULE1
    (rd_act && is_status_addr && mode_in == FSR_MODE_BASIC) |=> !host_data_oe_out)
    else $error("status read drove the bus in basic mode");

  status_readable_a: assert property ( // RULE2
    (rd_act && is_status_addr && mode_in != FSR_MODE_BASIC) |=> host_data_oe_out)
    else $error("status read not answered");

  step_latch_set_a: assert property ( // RULE5
    (core_in.step && !st_q.prev_step) |=> st_q.step_latch)
    else $error("step latch missed a step edge");

  step_latch_hold_a: assert property ( // RULE5
    (st_q.step_latch && !dir_read_in && !soft_rst) |=> st_q.step_latch)
    else $error("step latch cleared without cause");

  rdata_toggle_a: assert property ( // RULE7
    (pins_s.rdata_n && !st_q.prev_rdata_n) |=> (st_q.rdata_tog != $past(st_q.rdata_tog)))
    else $error("read data toggle did not flip");

  write_gate_latch_a: assert property ( // RULE10
    $rose(core_in.write_gate) |=> st_q.write_gate_latch)
    else $error("write gate latch missed an edge");

  drive_onehot_a: assert property ( // RULE13
    $onehot0(~st_q.ds_n))
    else $error("more than one drive selected");

  motor_write_a: assert property ( // RULE17
    dor_write_s |=> (motor_on_n_out == ~$past(wdat_motor)))
    else $error("motor outputs do not follow the write");

  soft_rst_len_a: assert property ( // RULE14
    soft_rst_write_s |=> !soft_reset_n_out [*2])
    else $error("software reset shorter than minimum");

  enh_dma_pins_a: assert property ( // RULE16
    (mode_in == FSR_MODE_ENHANCED) |=> dma_pins_enable_out)
    else $error("enhanced mode disabled the DMA pins");

  enh_srb_ones_a: assert property ( // RULE6
    (rd_act && addr_s == `FSR_OFS_SECOND_STATUS && mode_in == FSR_MODE_ENHANCED)
    |=> (host_data_out[7:6] == `FSR_SRB_ENH_ONES))
    else $error("enhanced second status top bits not set");

  dor_readback_a: assert property ( // RULE12
    (rd_act && addr_s == `FSR_OFS_DIGITAL_OUTPUT)
    |=> (host_data_oe_out && host_data_out == $past(st_q.digital_output_control)))
    else $error("output register read back wrong");

  dor_hold_a: assert property ( // RULE12
    !(wr_take && addr_s == `FSR_OFS_DIGITAL_OUTPUT) |=> $stable(st_q.digital_output_control))
    else $error("output register changed without a write");

  drive_decode_a: assert property ( // RULE13
    (st_q.digital_output_control[`FSR_DOR_SEL_HI:`FSR_DOR_SEL_LO] == 2'h0 && st_q.digital_output_control[`FSR_DOR_MOTOR_LO])
    |-> !drive_sel0_n_out)
    else $error("drive 0 not selected");

  dma_gate_a: assert property ( // RULE15
    (mode_in != FSR_MODE_ENHANCED) |=> (dma_pins_enable_out == dma_irq_enable_out))
    else $error("DMA pins do not follow the enable bit");

  write_gate_clear_a: assert property ( // RULE10
    (dir_read_in && !(core_in.write_gate && !st_q.prev_write_gate)) |=> !st_q.write_gate_latch)
    else $error("write gate latch not cleared by input register read");

  wdata_latch_a: assert property ( // RULE11
    (core_in.wdata_n && !st_q.prev_wdata_n) |=> st_q.wdata_latch)
    else $error("write data latch missed an edge");

endmodule

`default_nettype wire

/* File: verilog/fsr_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pins from outside the clock domain
module fsr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Both stages; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } fsr_sync_state_type;

  fsr_sync_state_type st_q;
  fsr_sync_state_type st_d;

  // Shift one stage per clock
  always_comb begin
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  // Reset to the idle level so strobes look inactive
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule

`default_nettype wire
